// *** design/gpx_pkg.sv ***
// Purpose: Shared constants for the multi-port GPIO block with port 2 edge interrupts
// Assumes: One register space with two banks, selected by the CPU-side bank bit
// Notes: Control register offsets and pin mode codes are fixed here for every file
package gpx_pkg;

  // Bank select values
  localparam logic BANK_PAGE8 = 1'b0;
  localparam logic BANK_SET1B1 = 1'b1;

  // Page 8: data registers of the nine ports
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h00;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h08;

  // Page 8: control registers, one after another from this base
  localparam logic [7:0] ADDR_CTRL_BASE = 8'h30;
  localparam logic [7:0] CTRL_COUNT = 8'h0B;
  localparam logic [7:0] ADDR_P2_PUR = 8'h3B;

  // Set 1, bank 1
  localparam logic [7:0] ADDR_P1_PUR = 8'hE4;
  localparam logic [7:0] ADDR_P1_OD = 8'hE5;
  localparam logic [7:0] ADDR_P2_IEN_HI = 8'hE8;
  localparam logic [7:0] ADDR_P2_IEN_LO = 8'hE9;
  localparam logic [7:0] ADDR_P2_PEND = 8'hEA;
  localparam logic [7:0] ADDR_P3_PUR = 8'hEE;
  localparam logic [7:0] ADDR_P3_OD = 8'hEF;

  // Control register index within the control block
  localparam int CTRL_P0_LOW = 0;
  localparam int CTRL_P3_LOW = 6;
  localparam int CTRL_P3_MID = 7;
  localparam int CTRL_P3_HIGH = 8;
  localparam int CTRL_P4_LOW = 9;

  // Port numbers with special behaviour
  localparam int PORT_OD1 = 1;
  localparam int PORT_IRQ = 2;
  localparam int PORT_OD3 = 3;
  localparam int PORT_ANALOG = 4;

  // Pin mode codes for ports 0, 1, 3 and 4
  localparam logic [1:0] MODE_IN = 2'h0;
  localparam logic [1:0] MODE_IN_PU = 2'h1;
  localparam logic [1:0] MODE_OUT = 2'h2;
  localparam logic [1:0] MODE_ALT = 2'h3;

  // Pin mode codes for port 2
  localparam logic [1:0] P2_IN_FALL = 2'h0;
  localparam logic [1:0] P2_IN_RISE = 2'h1;
  localparam logic [1:0] P2_IN_BOTH = 2'h2;
  localparam logic [1:0] P2_OUT = 2'h3;

  // Reset values and masks
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam logic [7:0] P8_MASK = 8'h3F;
  localparam logic [7:0] IEN_MASK = 8'h0F;

endpackage

// *** design/gpx_edge_det.sv ***
// Purpose: Per-pin edge detector for the port 2 external interrupt inputs
// Assumes: Levels arrive already registered in the core clock domain
// Notes: Detection is held off for the first cycle after reset
`timescale 1ns/1ns
module gpx_edge_det (
  input wire logic core_clk,        // System clock
  input wire logic rst,             // Synchronous reset, active high
  input wire logic [7:0] level,     // Registered port 2 levels
  input wire logic [15:0] mode,     // Two mode bits per pin
  input wire logic [7:0] enable,    // Per-pin interrupt enable
  output logic [7:0] event_hit      // Enabled edge seen this cycle
);

  typedef struct packed {
    logic armed;
    logic [7:0] prev;
  } gpx_edge_state_t;

  gpx_edge_state_t s_q;
  gpx_edge_state_t s_d;

  // Arming avoids a false edge from the reset value of prev
  always_comb begin
    s_d = s_q;
    s_d.armed = 1'b1;
    s_d.prev = level;
    if (rst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 8; g++) begin : g_pin
    logic rise;
    logic fall;
    logic [1:0] m;
    assign rise = level[g] & ~s_q.prev[g];
    assign fall = ~level[g] & s_q.prev[g];
    assign m = mode[2*g +: 2];
    assign event_hit[g] = s_q.armed & enable[g] &
      (((m == gpx_pkg::P2_IN_FALL) & fall) | ((m == gpx_pkg::P2_IN_RISE) & rise) |
       ((m == gpx_pkg::P2_IN_BOTH) & (rise | fall)));
  end

endmodule

// *** design/gpx_gpio_top.sv ***
// Purpose: Data latches for ports 0 to 8; direction and pull-up control for ports 0 to 4, open-drain for ports 1 and 3; port 2 interrupts
// Assumes: Pin inputs are synchronous to core_clk; CPU register strobes are single-cycle
// Notes: Ports 5 to 8 keep data latches only; their pin control lives elsewhere
`timescale 1ns/1ns

// How it works
// - Nine data registers at page 8 offsets 00H to 08H, read and write.
// - CPU reaches pins by plain reads and writes of the data registers.
// - Port 0 pins: input, input with pull-up, push-pull output, or LCD segment.
// - Two port 0 control bytes, high and low, cleared to input on reset.
// - Port 1 pins: inputs, push-pull or open-drain outputs, segments, peripherals.
// - Two port 1 control bytes select mode; reset makes all pins inputs.
// - Port 1 per-pin pull-up register at E4H, set 1 bank 1.
// - Port 1 per-pin open-drain select register at E5H, set 1 bank 1.
// - Port 2 pins: inputs, push-pull outputs, and external interrupt inputs 0 to 7.
// - Port 2 control clears to input; input picks falling, rising or both edges.
// - Port 2 enable high E8H, enable low E9H, pending EAH in set 1 bank 1.
// - Enabled selected edge sets its pending bit and pulls the request line low.
// - Pending bit stays set until software writes zero to it.
// - Pending register can be read at any time for polling.
// - Port 3 pins: inputs, push-pull or open-drain outputs, timer and pattern outputs.
// - Three port 3 control bytes for pins 5-7, 2-4 and 0-1, reset to input.
// - Port 3 pull-up register at EEH and open-drain select at EFH.
// - Port 4 pins: inputs, push-pull outputs, or analog converter inputs.
// - Port 8 has six pins, the other ports eight.
module gpx_gpio_top (
  input wire logic core_clk,               // System clock
  input wire logic rst,                    // Synchronous reset, active high
  input wire logic reg_bank1,              // 1 selects set 1 bank 1, 0 selects page 8
  input wire logic [7:0] reg_addr,         // Register offset
  input wire logic reg_wr,                 // Write strobe
  input wire logic reg_rd,                 // Read strobe
  input wire logic [7:0] reg_wdata,        // Write data
  output logic [7:0] reg_rdata,            // Read data, valid one cycle after reg_rd
  input wire logic [4:0][7:0] pin_in,      // Pin levels, ports 0 to 4
  input wire logic [4:0][7:0] alt_out,     // Segment and peripheral drive per pin
  output logic [4:0][7:0] pin_out,         // Pin output value
  output logic [4:0][7:0] pin_oe,          // Pin output enable, high drives
  output logic [4:0][7:0] pin_pullup,      // Pull-up enable per pin
  output logic [4:0][7:0] pin_level,       // Registered pin levels to peripherals
  output logic [7:0] analog_conv_sel,      // Port 4 pins handed to the converter
  output logic [2:0][7:0] port5_7_latch,   // Data latches of ports 5 to 7
  output logic [5:0] port8_latch,          // Data latch of port 8
  output logic irq_n                       // Interrupt request to CPU, active low
);

  typedef struct packed {
    logic [8:0][7:0] data;
    logic [10:0][7:0] ctrl;
    logic [7:0] pur1;
    logic [7:0] od1;
    logic [7:0] pur2;
    logic [7:0] pur3;
    logic [7:0] od3;
    logic [3:0] ien_hi;
    logic [3:0] ien_lo;
    logic [7:0] pend;
    logic [4:0][7:0] level;
    logic [4:0][7:0] pout;
    logic [4:0][7:0] poe;
    logic [4:0][7:0] ppu;
    logic [7:0] adc_sel;
    logic [7:0] rdata;
    logic irq_n;
  } gpx_state_t;

  gpx_state_t s_q;
  gpx_state_t s_d;
  logic [7:0] p2_event;
  logic [15:0] p2_mode;
  logic [7:0] p2_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Mode field of one pin; port 3 splits its pins 2/3/3 over three bytes
  function automatic logic [1:0] pin_mode(input logic [10:0][7:0] c, input int port,
                                          input int pin);
    logic [7:0] b;
    int f;
    int base;
    base = (port < 3) ? 2 * port : gpx_pkg::CTRL_P4_LOW;
    if (port == 3) begin
      if (pin < 2) begin
        b = c[gpx_pkg::CTRL_P3_LOW];
        f = pin;
      end else if (pin < 5) begin
        b = c[gpx_pkg::CTRL_P3_MID];
        f = pin - 2;
      end else begin
        b = c[gpx_pkg::CTRL_P3_HIGH];
        f = pin - 5;
      end
    end else begin
      b = (pin < 4) ? c[base] : c[base + 1];
      f = pin % 4;
    end
    return b[2*f +: 2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Port 2 edge detection
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p2_mode[2*i +: 2] = pin_mode(s_q.ctrl, gpx_pkg::PORT_IRQ, i);
    end
    p2_enable = {s_q.ien_hi, s_q.ien_lo};
  end

  gpx_edge_det u_edge (
    .core_clk (core_clk),
    .rst (rst),
    .level (s_q.level[gpx_pkg::PORT_IRQ]),
    .mode (p2_mode),
    .enable (p2_enable),
    .event_hit (p2_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [1:0] m;
    logic drv;
    logic val;
    logic pu;
    logic od;
    logic page8_wr;
    logic bank1_wr;
    logic [7:0] rd_val;
    logic [7:0] clr_mask;
    logic [7:0] ci;
    m = gpx_pkg::MODE_IN;
    drv = 1'b0;
    val = 1'b0;
    pu = 1'b0;
    od = 1'b0;
    rd_val = 8'h00;
    clr_mask = 8'h00;
    ci = reg_addr - gpx_pkg::ADDR_CTRL_BASE;
    page8_wr = reg_wr & (reg_bank1 == gpx_pkg::BANK_PAGE8);
    bank1_wr = reg_wr & (reg_bank1 == gpx_pkg::BANK_SET1B1);
    s_d = s_q;
    s_d.level = pin_in;

    // Register writes
    if (page8_wr && reg_addr <= gpx_pkg::ADDR_DATA_LAST) begin
      s_d.data[reg_addr[3:0]] = reg_wdata;
      if (reg_addr == gpx_pkg::ADDR_DATA_LAST) begin
        s_d.data[8] = reg_wdata & gpx_pkg::P8_MASK;
      end
    end
    if (page8_wr && reg_addr >= gpx_pkg::ADDR_CTRL_BASE && ci < gpx_pkg::CTRL_COUNT) begin
      s_d.ctrl[ci[3:0]] = reg_wdata;
    end
    if (page8_wr && reg_addr == gpx_pkg::ADDR_P2_PUR) begin
      s_d.pur2 = reg_wdata;
    end
    if (bank1_wr) begin
      unique case (reg_addr)
        gpx_pkg::ADDR_P1_PUR: s_d.pur1 = reg_wdata;
        gpx_pkg::ADDR_P1_OD: s_d.od1 = reg_wdata;
        gpx_pkg::ADDR_P2_IEN_HI: s_d.ien_hi = reg_wdata[3:0];
        gpx_pkg::ADDR_P2_IEN_LO: s_d.ien_lo = reg_wdata[3:0];
        gpx_pkg::ADDR_P2_PEND: clr_mask = ~reg_wdata;
        gpx_pkg::ADDR_P3_PUR: s_d.pur3 = reg_wdata;
        gpx_pkg::ADDR_P3_OD: s_d.od3 = reg_wdata;
        default: ;
      endcase
    end

    // A new edge in the clearing cycle keeps its pending bit
    s_d.pend = (s_q.pend & ~clr_mask) | p2_event;
    s_d.irq_n = ~|s_d.pend;

    // Pin drivers for ports 0 to 4
    for (int p = 0; p < 5; p++) begin
      for (int i = 0; i < 8; i++) begin
        m = pin_mode(s_q.ctrl, p, i);
        val = s_q.data[p][i];
        if (p == gpx_pkg::PORT_IRQ) begin
          drv = (m == gpx_pkg::P2_OUT);
          pu = s_q.pur2[i] & ~drv;
          od = 1'b0;
        end else begin
          // Port 4 alternative is analog: the pin must stay undriven
          drv = (m == gpx_pkg::MODE_OUT) |
                ((m == gpx_pkg::MODE_ALT) & (p != gpx_pkg::PORT_ANALOG));
          if (m == gpx_pkg::MODE_ALT) begin
            val = alt_out[p][i];
          end
          pu = ~drv & ((m == gpx_pkg::MODE_IN_PU) |
               ((p == gpx_pkg::PORT_OD1) & s_q.pur1[i]) |
               ((p == gpx_pkg::PORT_OD3) & s_q.pur3[i]));
          od = ((p == gpx_pkg::PORT_OD1) & s_q.od1[i]) |
               ((p == gpx_pkg::PORT_OD3) & s_q.od3[i]);
        end
        if (drv && od) begin
          s_d.pout[p][i] = 1'b0;
          s_d.poe[p][i] = ~val;
        end else begin
          s_d.pout[p][i] = val;
          s_d.poe[p][i] = drv;
        end
        s_d.ppu[p][i] = pu;
        if (p == gpx_pkg::PORT_ANALOG) begin
          s_d.adc_sel[i] = (m == gpx_pkg::MODE_ALT);
        end
      end
    end

    // Read mux; input pins show their sampled level
    if (reg_bank1 == gpx_pkg::BANK_PAGE8) begin
      if (reg_addr <= gpx_pkg::ADDR_DATA_LAST) begin
        rd_val = s_q.data[reg_addr[3:0]];
        if (reg_addr < 8'h05) begin
          rd_val = (s_q.level[reg_addr[2:0]] & ~s_q.poe[reg_addr[2:0]]) |
                   (s_q.data[reg_addr[2:0]] & s_q.poe[reg_addr[2:0]]);
        end
      end else if (reg_addr >= gpx_pkg::ADDR_CTRL_BASE && ci < gpx_pkg::CTRL_COUNT) begin
        rd_val = s_q.ctrl[ci[3:0]];
      end else if (reg_addr == gpx_pkg::ADDR_P2_PUR) begin
        rd_val = s_q.pur2;
      end
    end else begin
      unique case (reg_addr)
        gpx_pkg::ADDR_P1_PUR: rd_val = s_q.pur1;
        gpx_pkg::ADDR_P1_OD: rd_val = s_q.od1;
        gpx_pkg::ADDR_P2_IEN_HI: rd_val = {4'h0, s_q.ien_hi};
        gpx_pkg::ADDR_P2_IEN_LO: rd_val = {4'h0, s_q.ien_lo};
        gpx_pkg::ADDR_P2_PEND: rd_val = s_q.pend;
        gpx_pkg::ADDR_P3_PUR: rd_val = s_q.pur3;
        gpx_pkg::ADDR_P3_OD: rd_val = s_q.od3;
        default: rd_val = 8'h00;
      endcase
    end
    if (reg_rd) begin
      s_d.rdata = rd_val;
    end

    if (rst) begin
      s_d = '0;
      s_d.ctrl = {11{gpx_pkg::CTRL_RST}};
      s_d.data = {9{gpx_pkg::DATA_RST}};
      s_d.pend = gpx_pkg::PEND_RST;
      s_d.irq_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = s_q.rdata;
  assign pin_out = s_q.pout;
  assign pin_oe = s_q.poe;
  assign pin_pullup = s_q.ppu;
  assign pin_level = s_q.level;
  assign analog_conv_sel = s_q.adc_sel;
  assign port5_7_latch = s_q.data[7:5];
  assign port8_latch = s_q.data[8][5:0];
  assign irq_n = s_q.irq_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic pend_wr;
  assign pend_wr = reg_wr & reg_bank1 & (reg_addr == gpx_pkg::ADDR_P2_PEND);

  sequence s_pend_clear;
    pend_wr && (p2_event == 8'h00);
  endsequence

  sequence s_data_write_p5;
    reg_wr && !reg_bank1 && reg_addr == 8'h05;
  endsequence

  sequence s_read_p5;
    reg_rd && !reg_bank1 && reg_addr == 8'h05 && !reg_wr;
  endsequence

  AST_RESET_INPUTS: assert property (
    @(posedge core_clk) disable iff (1'b0) rst ##1 rst |=> pin_oe == '0)
    else $error("pins driven after reset");

  AST_PEND_SET: assert property (
    (p2_event != 8'h00) |=> ((s_q.pend & $past(p2_event)) == $past(p2_event)) && !irq_n)
    else $error("enabled edge did not set pending and request");

  AST_IRQ_FOLLOWS: assert property (
    irq_n == ~|s_q.pend)
    else $error("request line not tied to pending");

  AST_PEND_HOLD: assert property (
    !pend_wr |=> (s_q.pend & $past(s_q.pend)) == $past(s_q.pend))
    else $error("pending bit cleared without write");

  AST_PEND_CLEAR: assert property (
    s_pend_clear |=> s_q.pend == ($past(s_q.pend) & $past(reg_wdata)))
    else $error("zero write did not clear pending");

  AST_DATA_RW: assert property (
    s_data_write_p5 ##1 !reg_wr ##1 s_read_p5 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("data register read back wrong");

  AST_PEND_READ: assert property (
    (reg_rd && reg_bank1 && reg_addr == gpx_pkg::ADDR_P2_PEND) |=> reg_rdata == $past(s_q.pend))
    else $error("pending read wrong");

  AST_PUR1_WRITE: assert property (
    (reg_wr && reg_bank1 && reg_addr == gpx_pkg::ADDR_P1_PUR) |=> s_q.pur1 == $past(reg_wdata))
    else $error("port 1 pull-up register not written");

  AST_OPEN_DRAIN: assert property (
    (s_q.od1[0] && pin_mode(s_q.ctrl, 1, 0) == gpx_pkg::MODE_OUT) |=>
      pin_out[1][0] == 1'b0)
    else $error("open-drain pin drove high");

  AST_INPUT_MODE: assert property (
    (s_q.ctrl[gpx_pkg::CTRL_P0_LOW][1:0] == gpx_pkg::MODE_IN && $stable(s_q.ctrl)) |=>
      !pin_oe[0][0])
    else $error("input-mode pin driven");

  AST_P8_WIDTH: assert property (
    s_q.data[8][7:6] == 2'h0)
    else $error("port 8 upper bits stored");

  // An output-mode port 2 pin, checked here on pin 3, must never raise its pending bit
  sequence s_p2_pin3_out;
    pin_mode(s_q.ctrl, gpx_pkg::PORT_IRQ, 3) == gpx_pkg::P2_OUT && !s_q.pend[3];
  endsequence

  AST_P2_OUT_NO_PEND: assert property (
    s_p2_pin3_out |=> !s_q.pend[3])
    else $error("output-mode port 2 pin raised pending");

  AST_ANALOG_UNDRIVEN: assert property (
    analog_conv_sel[0] |-> !pin_oe[4][0])
    else $error("converter pin driven");

endmodule

// *** test/gpx_pin_model.sv ***
// Purpose: External pin model for ports 0 to 4 of the GPIO block
// Assumes: Bench supplies what outside circuits drive and where they drive it
// Notes: A pin that nobody drives and that has no pull-up shows a level that toggles each cycle
`timescale 1ns/1ns
module gpx_pin_model (
  input wire logic core_clk,             // System clock
  input wire logic [4:0][7:0] pin_out,   // Value the block drives
  input wire logic [4:0][7:0] pin_oe,    // Block drives the pin when high
  input wire logic [4:0][7:0] pin_pullup, // Pull-up enabled by the block
  input wire logic [4:0][7:0] ext_val,   // Level an outside circuit drives
  input wire logic [4:0][7:0] ext_en,    // Outside circuit drives when high
  output logic [4:0][7:0] pin_in         // Resolved pin level
);
  logic [4:0][7:0] float_q = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // Floating pins must not settle to a convenient value
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int i = 0; i < 8; i++) begin
        if (pin_oe[p][i]) begin
          pin_in[p][i] = pin_out[p][i];
        end else if (ext_en[p][i]) begin
          pin_in[p][i] = ext_val[p][i];
        end else if (pin_pullup[p][i]) begin
          pin_in[p][i] = 1'b1;
        end else begin
          pin_in[p][i] = float_q[p][i];
        end
      end
    end
  end
endmodule

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the multi-port GPIO block
// Assumes: Register strobes are one-cycle pulses driven 1 ns after the clock edge
// Notes: Plain register cases sit in a table; pins and interrupts are hand-written
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic bank; logic [7:0] addr; logic [7:0] wd; logic [7:0] exp;} gpx_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_bank1 = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [4:0][7:0] pin_in, alt_out, pin_out, pin_oe, pin_pullup, pin_level;
  logic [4:0][7:0] ext_val, ext_en;
  logic [7:0] analog_conv_sel;
  logic [2:0][7:0] port5_7_latch;
  logic [5:0] port8_latch;
  logic irq_n;
  int fails = 0;
  int checks_done = 0;
  gpx_row_t rows [16] = '{
    '{1'b0, 8'h31, 8'h3C, 8'h3C}, '{1'b0, 8'h33, 8'hC3, 8'hC3}, '{1'b0, 8'h35, 8'h96, 8'h96},
    '{1'b0, 8'h37, 8'h69, 8'h69}, '{1'b0, 8'h05, 8'hA5, 8'hA5}, '{1'b0, 8'h07, 8'h5A, 8'h5A},
    '{1'b0, 8'h08, 8'hFF, 8'h3F}, '{1'b1, 8'hE4, 8'h81, 8'h81}, '{1'b1, 8'hE5, 8'h42, 8'h42},
    '{1'b1, 8'hE8, 8'hFF, 8'h0F}, '{1'b1, 8'hE9, 8'hF5, 8'h05}, '{1'b1, 8'hEE, 8'h24, 8'h24},
    '{1'b1, 8'hEF, 8'h18, 8'h18}, '{1'b1, 8'h10, 8'hFF, 8'h00}, '{1'b0, 8'h2E, 8'hFF, 8'h00},
    '{1'b0, 8'h3B, 8'h7E, 8'h7E}};

  gpx_gpio_top i_gpx_gpio_top (.core_clk(core_clk), .rst(rst), .reg_bank1(reg_bank1),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .alt_out(alt_out), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_level(pin_level),
    .analog_conv_sel(analog_conv_sel), .port5_7_latch(port5_7_latch),
    .port8_latch(port8_latch), .irq_n(irq_n));

  gpx_pin_model i_gpx_pin_model (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Extra edge before raising a strobe keeps back-to-back calls from colliding
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_bank1 = b;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rdchk(input logic b, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    #1;
    reg_bank1 = b;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
    chk8(reg_rdata, exp);
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
  endtask

  // Pins follow a register write two edges later
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq_n !== exp && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (irq_n !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, irq_n, exp);
      close_out();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    alt_out = '0;
    ext_val = {8'hF0, 8'h00, 8'h11, 8'h00, 8'hC3};
    ext_en = {8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    chk1(irq_n, 1'b1);
    chk8(pin_oe[0] | pin_oe[1] | pin_oe[2] | pin_oe[3] | pin_oe[4], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].bank, rows[i].addr, rows[i].wd);
      rdchk(rows[i].bank, rows[i].addr, rows[i].exp);
    end
    chk8({2'b00, port8_latch}, 8'h3F);
    chk8(port5_7_latch[2], 8'h5A);
    do_reset();
    foreach (rows[i]) begin
      rdchk(rows[i].bank, rows[i].addr, 8'h00);
    end
    rdchk(1'b0, 8'h30, 8'h00);
    rdchk(1'b0, 8'h38, 8'h00);
    // Port 0: low pins outputs, high pins with pull-ups
    wr(1'b0, 8'h30, 8'hAA);
    wr(1'b0, 8'h31, 8'h55);
    wr(1'b0, 8'h00, 8'h5A);
    settle();
    chk8(pin_oe[0], 8'h0F);
    chk8({4'h0, pin_out[0][3:0]}, 8'h0A);
    chk8(pin_pullup[0], 8'hF0);
    rdchk(1'b0, 8'h00, 8'hCA);
    chk8(pin_level[0], 8'hCA);
    // Port 1 open drain on low pins, pull-ups on high pins
    wr(1'b0, 8'h32, 8'hAA);
    wr(1'b1, 8'hE5, 8'h0F);
    wr(1'b1, 8'hE4, 8'hF0);
    wr(1'b0, 8'h01, 8'h05);
    settle();
    chk8({4'h0, pin_oe[1][3:0]}, 8'h0A);
    chk8({4'h0, pin_out[1][3:0]}, 8'h00);
    chk8(pin_pullup[1], 8'hF0);
    // Port 3 low pins handed to a timer output
    alt_out[3] = 8'h02;
    wr(1'b0, 8'h36, 8'h0F);
    settle();
    chk8({6'h00, pin_out[3][1:0]}, 8'h02);
    chk8({6'h00, pin_oe[3][1:0]}, 8'h03);
    // Same pins as open drain: a high level releases the pin
    wr(1'b1, 8'hEF, 8'h03);
    settle();
    chk8({6'h00, pin_oe[3][1:0]}, 8'h01);
    chk8({6'h00, pin_out[3][1:0]}, 8'h00);
    // Port 4 low pins handed to the converter
    wr(1'b0, 8'h39, 8'hFF);
    settle();
    chk8(analog_conv_sel, 8'h0F);
    chk8({4'h0, pin_oe[4][3:0]}, 8'h00);
    // Port 2: pin0 falling, pin1 rising, pin2 both, pin3 output; pin4 not enabled
    wr(1'b0, 8'h34, 8'hE4);
    wr(1'b1, 8'hE9, 8'h0F);
    settle();
    chk1(irq_n, 1'b1);
    chk8(pin_oe[2], 8'h08);
    ext_val[2] = 8'h06;
    wait_irq(1'b0);
    rdchk(1'b1, 8'hEA, 8'h07);
    ext_val[2] = 8'h02;
    settle();
    wr(1'b1, 8'hEA, 8'hFF);
    rdchk(1'b1, 8'hEA, 8'h07);
    wr(1'b1, 8'hEA, 8'hFE);
    rdchk(1'b1, 8'hEA, 8'h06);
    chk1(irq_n, 1'b0);
    wr(1'b1, 8'hEA, 8'h00);
    wait_irq(1'b1);
    rdchk(1'b1, 8'hEA, 8'h00);
    // Pending bit and request cleared by a reset in mid-run
    // Wrong-direction edges on pins 0 and 1 are refused
    ext_val[2] = 8'h01;
    settle();
    rdchk(1'b1, 8'hEA, 8'h00);
    ext_val[2] = 8'h00;
    wait_irq(1'b0);
    do_reset();
    chk1(irq_n, 1'b1);
    rdchk(1'b1, 8'hEA, 8'h00);
    close_out();
  end
endmodule
